// [rtl/rsoe_pkg.sv]
// constants for the reset and output enable control block
// assumes byte-wide register access at 20-bit byte addresses
// Contract
// - Power-on reset always acts, initialises every register including the mask.
// - Enabled hard reset initialises registers except mask and clears valid flags.
// - PCI reset always initialises PCI side; back end only when enabled.
// - Enabled forwarding drives PCI reset onto bridge pin, polarity selectable.
// - Soft reset write triggers action then self-clears; zero is no-op default.
// - Command 01 resets registers and valid flags; 02 resets registers only.
// - Command 10 clears pending and in-service; 20 clears in-service only.
// - Command 40 clears vc_mem_a memory; 80 clears vc_notify_fifo FIFO.
// - Mask bit 0 gates all soft reset actions; defaults enabled.
// - Mask bits: 1 hard default 1, 2 pci 0, 3 forward 0; 7:4 zero.
// - All-outputs bit 7 acts as if bits 5:0 were all set; bridge bit 6 still needs its own bit.
// - Bit 5 gates frame-group register outputs, bit 4 GPIO; default off.
// - Bit 3 gates backplane clocks and frames, bit 2 backplane data.
// - Bit 1 gates local clocks and frames, bit 0 local data.
// - Error and reference select outputs ungated, driven except during reset.
// - In microprocessor mode the VC start and descriptor base read reserved.
// - Control and status registers decode within 0x00100 to 0x001FF.
// - Reserved addresses and bits read zero.
// - In microprocessor mode the bridge port enable bit is reserved.

package rsoe_pkg;
    // ======================================================
    // address map
    localparam logic [19:0] ADDR_SOFT_RESET = 20'h00100;
    localparam logic [19:0] ADDR_RESET_MASK = 20'h00101;
    localparam logic [19:0] ADDR_OUT_ENABLE = 20'h00103;
    localparam logic [19:0] ADDR_VC_START = 20'h00104;
    localparam logic [19:0] ADDR_DESC_BASE_LO = 20'h00110;
    localparam logic [19:0] ADDR_DESC_BASE_HI = 20'h00113;
    localparam logic [19:0] ADDR_RANGE_LO = 20'h00100;
    localparam logic [19:0] ADDR_RANGE_HI = 20'h001FF;

    // ======================================================
    // soft reset command bits
    localparam int CMD_REGS_AND_FLAGS = 0;
    localparam int CMD_REGS_ONLY = 1;
    localparam int CMD_IRQ_ALL = 4;
    localparam int CMD_IRQ_INSERVICE = 5;
    localparam int CMD_VC_PENDING_MEM = 6;
    localparam int CMD_VC_NOTIFY_FIFO = 7;
    localparam logic [7:0] SOFT_CMD_RESET = 8'h00;

    // ======================================================
    // reset mask fields
    localparam int MASK_SOFT_EN = 0;
    localparam int MASK_HARD_EN = 1;
    localparam int MASK_PCI_EN = 2;
    localparam int MASK_FWD_EN = 3;
    localparam logic [3:0] MASK_RESET = 4'h3;

    // ======================================================
    // output enable fields
    localparam int OE_LOCAL_DATA = 0;
    localparam int OE_LOCAL_CLOCK = 1;
    localparam int OE_BACK_DATA = 2;
    localparam int OE_BACK_CLOCK = 3;
    localparam int OE_GENERAL_IO = 4;
    localparam int OE_FRAME_GROUP = 5;
    localparam int OE_BRIDGE = 6;
    localparam int OE_ALL = 7;
    localparam logic [7:0] OE_RESET = 8'h00;
    localparam logic [6:0] OE_ALL_GROUPS = 7'h7F;
endpackage

// [rtl/rsoe_sync2.sv]
// two flip-flop level synchroniser for pin inputs
// assumes the pin is asynchronous to clock
`timescale 1ns/1ps

module rsoe_sync2
#(
    parameter logic RESET_VAL = 1'b1
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic asyncIn,
    output logic syncOut
);
    logic stage1_ff;
    logic stage2_ff;

    // ======================================================
    // first stage is read only by the second
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            stage1_ff <= RESET_VAL;
            stage2_ff <= RESET_VAL;
        end
        else
        begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign syncOut = stage2_ff;
endmodule

// [rtl/rsoe_reset_oe_ctrl.sv]
// reset distribution and master output enable control
// assumes rst_n is the power-on reset, already synchronous to clock;
// reset pins and the host select strap arrive asynchronously
// output enables are high while the matching pin drivers are on
`timescale 1ns/1ps

module rsoe_reset_oe_ctrl
(
    input wire logic clock,
    input wire logic rst_n,
    // pins
    input wire logic hardReset_n,
    input wire logic pciReset_n,
    input wire logic microHostSel,
    // forwarded reset polarity from the GPIO polarity register
    input wire logic bridgeResetPolarity,
    // register access
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [19:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic regInRange,
    output logic pciOnlyRegsEn,
    // reset actions
    output logic backendInit,
    output logic validFlagsClear,
    output logic pciIfInit,
    output logic irqPendingClear,
    output logic irqInServiceClear,
    output logic vcMemAClear,
    output logic vcNotifyFifoClear,
    // bridge forward on general_io_pin_two
    output logic bridgeResetForward,
    output logic generalIoPinTwoOut,
    // group output enables
    output logic localDataOe,
    output logic localClockOe,
    output logic backplaneDataOe,
    output logic backplaneClockOe,
    output logic generalIoOe,
    output logic frameGroupIoOe,
    output logic bridgePortOe,
    output logic alwaysOnOe
);
    // ======================================================
    // pin synchronisers
    logic hardResetSync_n;
    logic pciResetSync_n;
    logic microHostSync;

    // reset pins idle high, so the stages reset high and no false reset follows
    rsoe_sync2 #(.RESET_VAL(1'b1)) syncHard
    (
        .clock(clock),
        .rst_n(rst_n),
        .asyncIn(hardReset_n),
        .syncOut(hardResetSync_n)
    );

    // pci reset pin, same idle level
    rsoe_sync2 #(.RESET_VAL(1'b1)) syncPci
    (
        .clock(clock),
        .rst_n(rst_n),
        .asyncIn(pciReset_n),
        .syncOut(pciResetSync_n)
    );

    // host strap; reads as pci host until the strap has been seen
    rsoe_sync2 #(.RESET_VAL(1'b0)) syncMode
    (
        .clock(clock),
        .rst_n(rst_n),
        .asyncIn(microHostSel),
        .syncOut(microHostSync)
    );

    // ======================================================
    // registers
    logic [7:0] softCmd_ff;
    logic [3:0] resetMask_ff;
    logic [7:0] outEnable_ff;
    logic [7:0] rdData_ff;
    logic [7:0] actionPulse_ff;
    logic backendInit_ff;
    logic validClear_ff;
    logic pciInit_ff;
    logic fwdOut_ff;
    logic fwdActive_ff;
    logic [6:0] groupOe_ff;
    logic alwaysOn_ff;

    // next-state values for the command, mask, enable, read data and group registers
    logic [7:0] nxt_softCmd;
    logic [3:0] nxt_resetMask;
    logic [7:0] nxt_outEnable;
    logic [7:0] nxt_rdData;
    logic [6:0] nxt_groupOe;

    // ======================================================
    // address decode
    // exact byte match; the range flag covers the whole control block
    wire hitSoft = (regAddr == rsoe_pkg::ADDR_SOFT_RESET);
    wire hitMask = (regAddr == rsoe_pkg::ADDR_RESET_MASK);
    wire hitEnable = (regAddr == rsoe_pkg::ADDR_OUT_ENABLE);
    wire inRange = (regAddr >= rsoe_pkg::ADDR_RANGE_LO)
        && (regAddr <= rsoe_pkg::ADDR_RANGE_HI);
    wire wrSoft = regWrite && hitSoft;
    wire wrMask = regWrite && hitMask;
    wire wrEnable = regWrite && hitEnable;

    // ======================================================
    // reset sources
    wire softEn = resetMask_ff[rsoe_pkg::MASK_SOFT_EN];
    wire hardEn = resetMask_ff[rsoe_pkg::MASK_HARD_EN];
    wire pciEn = resetMask_ff[rsoe_pkg::MASK_PCI_EN];
    wire fwdEn = resetMask_ff[rsoe_pkg::MASK_FWD_EN];
    // pins are active low; the mask decides whether they reach the back end
    wire pciActive = !pciResetSync_n;
    wire hardActive = !hardResetSync_n && hardEn;
    wire pciBackend = pciActive && pciEn;
    // soft actions come from last cycle's command, gated by the mask
    wire [7:0] softAct = softEn ? softCmd_ff : rsoe_pkg::SOFT_CMD_RESET;
    wire softRegs = softAct[rsoe_pkg::CMD_REGS_AND_FLAGS]
        || softAct[rsoe_pkg::CMD_REGS_ONLY];
    wire softFlags = softAct[rsoe_pkg::CMD_REGS_AND_FLAGS];
    // back end initialise: every register bar the reset mask
    // init wins over a register write landing in the same cycle
    wire initAll = hardActive || pciBackend || softRegs;
    wire clearFlags = hardActive || pciBackend || softFlags;

    // ======================================================
    // soft command: stored for one cycle then cleared as a whole
    always_comb
    begin
        nxt_softCmd = rsoe_pkg::SOFT_CMD_RESET;
        if (wrSoft)
        begin
            nxt_softCmd = regWrData;
        end
    end

    // ======================================================
    // reset mask: only power-on reset restores it
    always_comb
    begin
        nxt_resetMask = resetMask_ff;
        if (wrMask)
        begin
            nxt_resetMask = regWrData[3:0];
        end
    end

    // ======================================================
    // master enable; bridge bit is reserved in microprocessor mode
    // an enable write lost to an init must be repeated by software
    always_comb
    begin
        nxt_outEnable = outEnable_ff;
        if (initAll)
        begin
            nxt_outEnable = rsoe_pkg::OE_RESET;
        end
        else if (wrEnable)
        begin
            nxt_outEnable = regWrData;
            if (microHostSync)
            begin
                nxt_outEnable[rsoe_pkg::OE_BRIDGE] = 1'b0;
            end
        end
    end

    // ======================================================
    // effective group enables, all off during any back-end init
    wire [6:0] groupBits = outEnable_ff[rsoe_pkg::OE_ALL]
        ? rsoe_pkg::OE_ALL_GROUPS : outEnable_ff[6:0];
    // bridge needs its own bit even when all-outputs is set
    wire bridgeOk = outEnable_ff[rsoe_pkg::OE_BRIDGE] && !microHostSync;

    always_comb
    begin
        nxt_groupOe = groupBits;
        nxt_groupOe[rsoe_pkg::OE_BRIDGE] = bridgeOk;
        if (initAll)
        begin
            nxt_groupOe = 7'h00;
        end
    end

    // ======================================================
    // read mux; unmapped and reserved fields return zero
    always_comb
    begin
        nxt_rdData = 8'h00;
        if (regRead && hitMask)
        begin
            nxt_rdData = {4'h0, resetMask_ff};
        end
        else if (regRead && hitEnable)
        begin
            nxt_rdData = outEnable_ff;
            if (microHostSync)
            begin
                nxt_rdData[rsoe_pkg::OE_BRIDGE] = 1'b0;
            end
        end
    end

    // ======================================================
    // state update
    // the mask is left alone by hard, pci and soft resets
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            resetMask_ff <= rsoe_pkg::MASK_RESET;
            outEnable_ff <= rsoe_pkg::OE_RESET;
            softCmd_ff <= rsoe_pkg::SOFT_CMD_RESET;
            rdData_ff <= 8'h00;
        end
        else
        begin
            resetMask_ff <= nxt_resetMask;
            outEnable_ff <= nxt_outEnable;
            softCmd_ff <= nxt_softCmd;
            rdData_ff <= nxt_rdData;
        end
    end

    // ======================================================
    // reset action outputs, registered; power-on drives all inits
    // pulses come one cycle after the command, so combined bits act together
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            backendInit_ff <= 1'b1;
            validClear_ff <= 1'b1;
            pciInit_ff <= 1'b1;
            actionPulse_ff <= 8'h00;
        end
        else
        begin
            backendInit_ff <= initAll;
            validClear_ff <= clearFlags;
            pciInit_ff <= pciActive;
            actionPulse_ff <= softAct;
        end
    end

    // ======================================================
    // bridge forward and enables; drivers off while in reset
    // forwarded level trails the synced pin by one cycle
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            fwdActive_ff <= 1'b0;
            fwdOut_ff <= 1'b0;
            groupOe_ff <= 7'h00;
            alwaysOn_ff <= 1'b0;
        end
        else
        begin
            fwdActive_ff <= fwdEn;
            fwdOut_ff <= pciActive ^ bridgeResetPolarity;
            groupOe_ff <= nxt_groupOe;
            alwaysOn_ff <= !initAll;
        end
    end

    // ======================================================
    // output assignments
    assign regRdData = rdData_ff;
    assign regInRange = inRange;
    assign pciOnlyRegsEn = !microHostSync;

    // reset actions toward the back end
    assign backendInit = backendInit_ff;
    assign validFlagsClear = validClear_ff;
    assign pciIfInit = pciInit_ff;
    assign irqPendingClear = actionPulse_ff[rsoe_pkg::CMD_IRQ_ALL];
    assign irqInServiceClear = actionPulse_ff[rsoe_pkg::CMD_IRQ_ALL]
        || actionPulse_ff[rsoe_pkg::CMD_IRQ_INSERVICE];
    assign vcMemAClear = actionPulse_ff[rsoe_pkg::CMD_VC_PENDING_MEM];
    assign vcNotifyFifoClear = actionPulse_ff[rsoe_pkg::CMD_VC_NOTIFY_FIFO];

    // bridge forward on the second general-purpose pin
    assign bridgeResetForward = fwdActive_ff;
    assign generalIoPinTwoOut = fwdActive_ff && fwdOut_ff;

    // group enables, high while the drivers are on
    assign localDataOe = groupOe_ff[rsoe_pkg::OE_LOCAL_DATA];
    assign localClockOe = groupOe_ff[rsoe_pkg::OE_LOCAL_CLOCK];
    assign backplaneDataOe = groupOe_ff[rsoe_pkg::OE_BACK_DATA];
    assign backplaneClockOe = groupOe_ff[rsoe_pkg::OE_BACK_CLOCK];
    assign generalIoOe = groupOe_ff[rsoe_pkg::OE_GENERAL_IO];
    assign frameGroupIoOe = groupOe_ff[rsoe_pkg::OE_FRAME_GROUP];
    assign bridgePortOe = groupOe_ff[rsoe_pkg::OE_BRIDGE];
    assign alwaysOnOe = alwaysOn_ff;
endmodule

// [verification/rsoe_host_model.sv]
// host processor model issuing byte register accesses
// assumes a strobe is taken on the rising edge where it is high
`timescale 1ns/1ps

module rsoe_host_model
(
    input wire logic clock,
    input wire logic [7:0] regRdData,
    output logic regWrite,
    output logic regRead,
    output logic [19:0] regAddr,
    output logic [7:0] regWrData
);
    // ======================================================
    // idle bus from time zero
    initial
    begin
        {regWrite, regRead, regAddr, regWrData} = 30'h0;
    end

    // one-cycle write strobe, one idle cycle before it
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        {regWrite, regAddr, regWrData} = {1'b1, a, d};
        @(posedge clock);
        #1;
        regWrite = 1'b0;
    endtask

    // read data is registered, so it stands in the cycle after the strobe
    task automatic rd(input logic [19:0] a, output logic [7:0] d);
        @(posedge clock);
        #1;
        {regRead, regAddr} = {1'b1, a};
        @(posedge clock);
        #1;
        regRead = 1'b0;
        d = regRdData;
    endtask
endmodule

// [verification/rsoe_reset_oe_ctrl_properties.sv]
// timing checks on the ports of the reset and output enable block
// assumes one clock domain; figures follow the hand-over walk
`timescale 1ns/1ps

module rsoe_reset_oe_ctrl_chk
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic pciReset_n,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [19:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic backendInit,
    input wire logic validFlagsClear,
    input wire logic pciIfInit,
    input wire logic irqPendingClear,
    input wire logic irqInServiceClear,
    input wire logic vcMemAClear,
    input wire logic vcNotifyFifoClear,
    input wire logic localDataOe,
    input wire logic frameGroupIoOe,
    input wire logic alwaysOnOe
);
    // ======================================================
    // helpers
    logic softEn_ff;
    logic nxt_softEn;
    logic wrSoft;
    logic wrOe;
    logic wrMask;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // shadow of the soft enable; only power-on reset restores it
    assign wrSoft = regWrite && regAddr == rsoe_pkg::ADDR_SOFT_RESET;
    assign wrOe = regWrite && regAddr == rsoe_pkg::ADDR_OUT_ENABLE;
    assign wrMask = regWrite && regAddr == rsoe_pkg::ADDR_RESET_MASK;
    assign nxt_softEn = wrMask ? regWrData[0] : softEn_ff;
    always_ff @(posedge clock)
    begin
        softEn_ff <= rst_n ? nxt_softEn : 1'b1;
    end

    // ======================================================
    // properties
    sequence s_cmd(logic [7:0] c);
        wrSoft && softEn_ff && regWrData == c;
    endsequence
    property p_por;
        disable iff (1'b0) !rst_n ##1 !rst_n |-> backendInit && pciIfInit && !alwaysOnOe;
    endproperty
    property p_init_all;
        s_cmd(8'h01) |-> ##2 backendInit && validFlagsClear;
    endproperty
    property p_irq;
        s_cmd(8'h10) |-> ##2 irqPendingClear && irqInServiceClear ##1 !irqPendingClear;
    endproperty
    property p_vc;
        s_cmd(8'hF0) |-> ##2 vcMemAClear && vcNotifyFifoClear && irqInServiceClear;
    endproperty
    property p_masked;
        wrSoft && !softEn_ff |-> ##2 !irqPendingClear && !irqInServiceClear;
    endproperty
    // no init may swallow the write nor force the groups off behind it
    sequence s_no_init;
        !backendInit ##1 !backendInit;
    endsequence
    property p_oe;
        wrOe ##1 s_no_init
            |-> localDataOe == ($past(regWrData[0], 2) | $past(regWrData[7], 2))
            && frameGroupIoOe == ($past(regWrData[5], 2) | $past(regWrData[7], 2));
    endproperty
    property p_rd_rsvd;
        regRead && regAddr == 20'h00102 |=> regRdData == 8'h00;
    endproperty
    property p_on;
        $rose(rst_n) |-> ##[1:2] alwaysOnOe;
    endproperty
    property p_pci;
        $fell(pciReset_n) |-> ##[3:4] pciIfInit;
    endproperty

    a_por: assert property (p_por) else $error("power-on reset not applied");
    a_init_all: assert property (p_init_all) else $error("command 01 missed");
    a_irq: assert property (p_irq) else $error("command 10 wrong");
    a_vc: assert property (p_vc) else $error("combined command wrong");
    a_masked: assert property (p_masked) else $error("masked soft reset acted");
    a_oe: assert property (p_oe) else $error("group enable mismatch");
    a_rd_rsvd: assert property (p_rd_rsvd) else $error("reserved read not zero");
    a_on: assert property (p_on) else $error("ungated outputs not driven");
    a_pci: assert property (p_pci) else $error("pci reset not applied");
endmodule

bind rsoe_reset_oe_ctrl rsoe_reset_oe_ctrl_chk chk
(
    .clock(clock), .rst_n(rst_n), .pciReset_n(pciReset_n), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .backendInit(backendInit), .validFlagsClear(validFlagsClear), .pciIfInit(pciIfInit),
    .irqPendingClear(irqPendingClear), .irqInServiceClear(irqInServiceClear),
    .vcMemAClear(vcMemAClear), .vcNotifyFifoClear(vcNotifyFifoClear),
    .localDataOe(localDataOe), .frameGroupIoOe(frameGroupIoOe), .alwaysOnOe(alwaysOnOe)
);

// [verification/reset_and_output_enable_ctrl_tb.sv]
// self-checking bench for the reset and output enable block
// assumes the host model is the only register bus master
`timescale 1ns/1ps

module reset_and_output_enable_ctrl_tb;
    logic clock, rst_n, hardReset_n, pciReset_n, microHostSel, bridgeResetPolarity;
    logic regWrite, regRead, regInRange, pciOnlyRegsEn;
    logic [19:0] regAddr;
    logic [7:0] regWrData, regRdData, rdVal, oeVec, act, pinVec;
    logic backendInit, validFlagsClear, pciIfInit, irqPendingClear, irqInServiceClear;
    logic vcMemAClear, vcNotifyFifoClear, bridgeResetForward, generalIoPinTwoOut;
    logic localDataOe, localClockOe, backplaneDataOe, backplaneClockOe, generalIoOe;
    logic frameGroupIoOe, bridgePortOe, alwaysOnOe;
    int nErrors = 0;
    int samplesChecked = 0;
    rsoe_reset_oe_ctrl uut
    (
        .clock(clock), .rst_n(rst_n), .hardReset_n(hardReset_n), .pciReset_n(pciReset_n),
        .microHostSel(microHostSel), .bridgeResetPolarity(bridgeResetPolarity),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .regInRange(regInRange), .pciOnlyRegsEn(pciOnlyRegsEn),
        .backendInit(backendInit), .validFlagsClear(validFlagsClear), .pciIfInit(pciIfInit),
        .irqPendingClear(irqPendingClear), .irqInServiceClear(irqInServiceClear),
        .vcMemAClear(vcMemAClear), .vcNotifyFifoClear(vcNotifyFifoClear),
        .bridgeResetForward(bridgeResetForward), .generalIoPinTwoOut(generalIoPinTwoOut),
        .localDataOe(localDataOe), .localClockOe(localClockOe),
        .backplaneDataOe(backplaneDataOe), .backplaneClockOe(backplaneClockOe),
        .generalIoOe(generalIoOe), .frameGroupIoOe(frameGroupIoOe),
        .bridgePortOe(bridgePortOe), .alwaysOnOe(alwaysOnOe)
    );
    rsoe_host_model host
    (
        .clock(clock), .regRdData(regRdData), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWrData(regWrData)
    );
    // ======================================================
    // views and clock
    assign oeVec = {alwaysOnOe, bridgePortOe, frameGroupIoOe, generalIoOe,
        backplaneClockOe, backplaneDataOe, localClockOe, localDataOe};
    assign act = {2'b00, backendInit, validFlagsClear, irqPendingClear,
        irqInServiceClear, vcMemAClear, vcNotifyFifoClear};
    assign pinVec = {4'h0, generalIoPinTwoOut, bridgeResetForward, backendInit, pciIfInit};
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // ======================================================
    // helpers
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            nErrors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic stopTest();
        if (nErrors == 0 && samplesChecked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ======================================================
    // scenarios
    task automatic t_defaults();
        host.rd(20'h00101, rdVal);
        check("mask", rdVal, 8'h03);
        check("in range", {7'h00, regInRange}, 8'h01);
        host.rd(20'h00200, rdVal);
        check("outside", {7'h00, regInRange}, 8'h00);
        host.rd(20'h00102, rdVal);
        check("reserved", rdVal, 8'h00);
        check("groups", oeVec, 8'h80);
    endtask
    task automatic t_enables();
        for (int i = 0; i < 8; i++)
        begin
            host.wr(20'h00103, 8'h01 << i);
            step(1);
            check("groups", oeVec, (i == 7) ? 8'hBF : (8'h80 | (8'h01 << i)));
        end
        host.wr(20'h00103, 8'hC0);
        step(1);
        check("all groups", oeVec, 8'hFF);
    endtask
    // every command plus a combined one; 01 and 02 also clear the enables
    task automatic t_soft();
        logic [7:0] cmds [7] = '{8'h01, 8'h02, 8'h10, 8'h20, 8'h40, 8'h80, 8'hF0};
        logic [7:0] acts [7] = '{8'h30, 8'h20, 8'h0C, 8'h04, 8'h02, 8'h01, 8'h0F};
        for (int i = 0; i < 7; i++)
        begin
            host.wr(20'h00103, 8'h01);
            host.wr(20'h00100, cmds[i]);
            step(1);
            check("actions", act, acts[i]);
            step(1);
            check("self clear", act, 8'h00);
            check("data enable", {7'h00, localDataOe}, {7'h00, i > 1});
        end
        host.rd(20'h00101, rdVal);
        check("mask kept", rdVal, 8'h03);
    endtask
    task automatic t_micro();
        microHostSel = 1'b1;
        step(4);
        check("pci regs", {7'h00, pciOnlyRegsEn}, 8'h00);
        host.wr(20'h00103, 8'h41);
        step(1);
        check("bridge", oeVec, 8'h81);
        host.rd(20'h00103, rdVal);
        check("bridge bit", rdVal, 8'h01);
        microHostSel = 1'b0;
    endtask
    // soft off, hard, pci and forward on; then pins with mask changes
    task automatic t_pins();
        host.wr(20'h00101, 8'hFE);
        check("pci regs on", {7'h00, pciOnlyRegsEn}, 8'h01);
        host.wr(20'h00100, 8'h30);
        step(1);
        check("masked", act, 8'h00);
        host.rd(20'h00101, rdVal);
        check("mask bits", rdVal, 8'h0E);
        pciReset_n = 1'b0;
        step(5);
        check("pci fwd", pinVec, 8'h0F);
        bridgeResetPolarity = 1'b1;
        step(2);
        check("inverted", {7'h00, generalIoPinTwoOut}, 8'h00);
        pciReset_n = 1'b1;
        step(5);
        check("pci idle", pinVec, 8'h0C);
        host.wr(20'h00101, 8'h01);
        {hardReset_n, pciReset_n} = 2'b00;
        step(5);
        check("masked pins", pinVec, 8'h01);
        {hardReset_n, pciReset_n} = 2'b11;
        host.wr(20'h00101, 8'h03);
        hardReset_n = 1'b0;
        step(5);
        check("hard init", {5'h00, backendInit, validFlagsClear, pciIfInit}, 8'h06);
        check("groups off", oeVec, 8'h00);
        hardReset_n = 1'b1;
        step(5);
    endtask

    // ======================================================
    // main sequence and watchdog
    initial
    begin
        {rst_n, hardReset_n, pciReset_n, microHostSel, bridgeResetPolarity} = 5'b01100;
        step(10);
        rst_n = 1'b1;
        t_defaults();
        t_enables();
        t_soft();
        t_micro();
        t_pins();
        host.wr(20'h00101, 8'h0C);
        rst_n = 1'b0;
        step(10);
        rst_n = 1'b1;
        host.rd(20'h00101, rdVal);
        check("mask after reset", rdVal, 8'h03);
        check("groups after reset", oeVec, 8'h80);
        stopTest();
    end
    initial
    begin
        #50000;
        nErrors++;
        stopTest();
    end
endmodule
